// ==== dv/async_serial_control_asserts.sv ====
// Checker: port-level properties of the serial port
`timescale 1ns/1ns
module async_serial_control_asserts #(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  logic ph_v;
  logic ph_w;
  logic rd_ph;
  logic [7:0] ph_i;
  logic [7:0] ctl2_sh;
  logic [7:0] rate_sh;
  logic [3:0] mask_sh;
  logic [8:0] brk_cnt;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Data phase tracking and shadows of written controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_v <= 1'b0;
      ph_w <= 1'b0;
      ph_i <= 8'h00;
      ctl2_sh <= 8'h00;
      rate_sh <= 8'h00;
      mask_sh <= 4'hf;
      brk_cnt <= 9'h000;
    end else begin
      if (hready) begin
        ph_v <= hsel && htrans == serial_pkg::HTRANS_NONSEQ;
        ph_w <= hwrite;
        ph_i <= haddr[9:2];
      end
      if (ph_v && ph_w && hready) begin
        if (ph_i == serial_pkg::IDX_CTL2) ctl2_sh <= hwdata[7:0];
        if (ph_i == serial_pkg::IDX_RATE) rate_sh <= hwdata[7:0];
        if (ph_i == serial_pkg::IDX_IRQ_MASK) mask_sh <= hwdata[3:0];
      end
      if (ctl2_sh[3] && ctl2_sh[0]) brk_cnt <= brk_cnt + 9'h001;
      else brk_cnt <= 9'h000;
    end
  end

  // Read data phase of any register
  assign rd_ph = ph_v && !ph_w;

  property p_bus_word; rd_ph |-> hrdata[31:8] == 24'h0 && !hresp; endproperty
  a_bus_word: assert property (p_bus_word)
    else $error("read data phase malformed");
  property p_ctl1_gaps;
    rd_ph && ph_i == serial_pkg::IDX_CTL1 |-> !hrdata[5] && hrdata[2:0] == 3'h0;
  endproperty
  a_ctl1_gaps: assert property (p_ctl1_gaps)
    else $error("unused control bits not zero");
  property p_ctl2_back; rd_ph && ph_i == serial_pkg::IDX_CTL2 |->
    {hrdata[7:2], hrdata[0]} == {ctl2_sh[7:2], ctl2_sh[0]}; endproperty
  a_ctl2_back: assert property (p_ctl2_back)
    else $error("control two readback differs");
  property p_tx_off; (!ctl2_sh[3])[*3] |-> txd; endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("line driven while transmitter off");
  property p_mask_quiet; (mask_sh == 4'h0)[*2] |-> !irq; endproperty
  a_mask_quiet: assert property (p_mask_quiet)
    else $error("irq with all sources masked");
  property p_break; rate_sh == 8'h00 && brk_cnt > 9'd300 |-> !txd; endproperty
  a_break: assert property (p_break)
    else $error("line not held low in break");
  property p_start; $fell(txd) && rate_sh == 8'h00 && brk_cnt == 9'h000
    |-> (!txd)[*8] ##1 (!txd)[*8]; endproperty
  a_start: assert property (p_start)
    else $error("start bit shorter than sixteen ticks");
  property p_irq_lvl; rd_ph && ph_i == serial_pkg::IDX_IRQ_STATUS &&
    (hrdata[3:0] & mask_sh) != 4'h0 |-> ##[0:1] irq; endproperty
  a_irq_lvl: assert property (p_irq_lvl)
    else $error("unmasked event without irq");
endmodule : async_serial_control_asserts

// ==== dv/async_serial_control_tb_top.sv ====
// Testbench: register, interrupt and serial traffic checks
`timescale 1ns/1ns
module async_serial_control_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rxd;
  logic txd;
  logic irq;
  logic nine = 1'b0;
  logic [7:0] en[2] = '{8'h84, 8'h44};
  logic [7:0] bitv[2] = '{8'h01, 8'h02};
  int err_total = 0;
  int checks_done = 0;
  int n;

  always #20 hclk = ~hclk;

  async_serial_control async_serial_control_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxd(rxd), .txd(txd), .irq(irq));
  serial_station serial_station_i (.txd(txd), .nine(nine), .rxd(rxd));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    htrans <= serial_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, i, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] i, input logic [7:0] m,
                     input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, i, 8'h00, q);
    chk(q & {24'h0, m}, {24'h0, e});
  endtask : rdc

  task automatic irq_is(input logic v);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, {31'h0, v});
  endtask : irq_is

  task automatic got_is(input int i, input logic [8:0] e);
    chk({23'h0, serial_station_i.got[i]}, {23'h0, e});
  endtask : got_is

  task automatic wait_got(input int k);
    repeat (3000) if (serial_station_i.got.size() < k) @(posedge hclk);
    repeat (20) @(posedge hclk);
  endtask : wait_got

  task automatic results();
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // Watchdog against a hung handshake or frame
  initial begin
    #2000000;
    err_total++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(serial_pkg::IDX_CTL2, 8'hff, 8'h00);
    rdc(serial_pkg::IDX_STATUS, 8'hff, 8'hc0);
    rdc(serial_pkg::IDX_IRQ_MASK, 8'hff, 8'h0f);
    rdc(8'h3f, 8'hff, 8'h00);
    wr(serial_pkg::IDX_CTL1, 8'hff);
    rdc(serial_pkg::IDX_CTL1, 8'hff, 8'h58);
    wr(serial_pkg::IDX_CTL1, 8'h00);
    // Two characters queued back to back
    wr(serial_pkg::IDX_CTL2, 8'h08);
    wr(serial_pkg::IDX_DATA, 8'ha5);
    rdc(serial_pkg::IDX_STATUS, 8'h80, 8'h80);
    wr(serial_pkg::IDX_DATA, 8'h3c);
    rdc(serial_pkg::IDX_STATUS, 8'hc0, 8'h00);
    wait_got(2);
    got_is(0, 9'h0a5);
    got_is(1, 9'h03c);
    rdc(serial_pkg::IDX_STATUS, 8'hc0, 8'hc0);
    // Nine-bit frames reuse the kept ninth bit
    nine <= 1'b1;
    wr(serial_pkg::IDX_CTL1, 8'h50);
    wr(serial_pkg::IDX_DATA, 8'h81);
    wait_got(3);
    wr(serial_pkg::IDX_DATA, 8'h02);
    wait_got(4);
    got_is(2, 9'h181);
    got_is(3, 9'h102);
    chk(serial_station_i.bad_stop, 32'h0);
    // Break held, then released
    wr(serial_pkg::IDX_CTL2, 8'h09);
    repeat (400) @(posedge hclk);
    chk({31'h0, txd}, 32'h0);
    wr(serial_pkg::IDX_CTL2, 8'h08);
    repeat (400) @(posedge hclk);
    chk({31'h0, txd}, 32'h1);
    nine <= 1'b0;
    wr(serial_pkg::IDX_CTL1, 8'h00);
    // Receive, request, flag clear by status then data read
    wr(serial_pkg::IDX_CTL2, 8'h24);
    wr(serial_pkg::IDX_IRQ_STATUS, 8'h0f);
    serial_station_i.send(9'h05a, 1'b0, 1'b1);
    rdc(serial_pkg::IDX_IRQ_STATUS, 8'h04, 8'h04);
    irq_is(1'b1);
    rdc(serial_pkg::IDX_STATUS, 8'h20, 8'h20);
    rdc(serial_pkg::IDX_DATA, 8'hff, 8'h5a);
    rdc(serial_pkg::IDX_STATUS, 8'h20, 8'h00);
    wr(serial_pkg::IDX_IRQ_STATUS, 8'h0f);
    rdc(serial_pkg::IDX_IRQ_STATUS, 8'h0f, 8'h00);
    // Holding-empty and done requests: raise, mask, clear
    for (int k = 0; k < 2; k++) begin
      wr(serial_pkg::IDX_CTL2, en[k]);
      rdc(serial_pkg::IDX_IRQ_STATUS, 8'h03, bitv[k]);
      irq_is(1'b1);
      wr(serial_pkg::IDX_IRQ_MASK, 8'h00);
      irq_is(1'b0);
      wr(serial_pkg::IDX_IRQ_MASK, 8'h0f);
      wr(serial_pkg::IDX_CTL2, 8'h04);
      wr(serial_pkg::IDX_IRQ_STATUS, 8'h0f);
      irq_is(1'b0);
    end
    // Overrun, then a zero stop bit
    serial_station_i.send(9'h001, 1'b0, 1'b1);
    serial_station_i.send(9'h002, 1'b0, 1'b1);
    rdc(serial_pkg::IDX_STATUS, 8'h08, 8'h08);
    rdc(serial_pkg::IDX_DATA, 8'hff, 8'h01);
    serial_station_i.send(9'h003, 1'b0, 1'b0);
    rdc(serial_pkg::IDX_STATUS, 8'h0a, 8'h02);
    rdc(serial_pkg::IDX_DATA, 8'hff, 8'h03);
    // Sleep until an address mark arrives
    wr(serial_pkg::IDX_CTL1, 8'h08);
    wr(serial_pkg::IDX_CTL2, 8'h26);
    wr(serial_pkg::IDX_IRQ_STATUS, 8'h0f);
    serial_station_i.send(9'h012, 1'b0, 1'b1);
    rdc(serial_pkg::IDX_STATUS, 8'h20, 8'h00);
    rdc(serial_pkg::IDX_IRQ_STATUS, 8'h04, 8'h00);
    serial_station_i.send(9'h092, 1'b0, 1'b1);
    rdc(serial_pkg::IDX_STATUS, 8'h20, 8'h20);
    rdc(serial_pkg::IDX_DATA, 8'hff, 8'h92);
    // Idle line after a frame
    wr(serial_pkg::IDX_CTL1, 8'h00);
    wr(serial_pkg::IDX_CTL2, 8'h14);
    serial_station_i.send(9'h055, 1'b0, 1'b1);
    repeat (400) @(posedge hclk);
    rdc(serial_pkg::IDX_IRQ_STATUS, 8'h08, 8'h08);
    irq_is(1'b1);
    rdc(serial_pkg::IDX_STATUS, 8'h30, 8'h30);
    rdc(serial_pkg::IDX_DATA, 8'hff, 8'h55);
    // Idle line ends sleep when waking by idle
    wr(serial_pkg::IDX_CTL2, 8'h06);
    serial_station_i.send(9'h033, 1'b0, 1'b1);
    rdc(serial_pkg::IDX_CTL2, 8'h02, 8'h02);
    repeat (200) @(posedge hclk);
    rdc(serial_pkg::IDX_CTL2, 8'h02, 8'h00);
    rdc(serial_pkg::IDX_STATUS, 8'h20, 8'h00);
    // Receiver off ignores a frame
    wr(serial_pkg::IDX_CTL2, 8'h00);
    serial_station_i.send(9'h077, 1'b0, 1'b1);
    rdc(serial_pkg::IDX_STATUS, 8'h20, 8'h00);
    // Slower rate: prescale by three, divide by two
    wr(serial_pkg::IDX_RATE, 8'h11);
    serial_station_i.bit_ns = 3840;
    n = serial_station_i.got.size();
    wr(serial_pkg::IDX_CTL2, 8'h08);
    wr(serial_pkg::IDX_DATA, 8'h6b);
    wait_got(n + 1);
    got_is(n, 9'h06b);
    // Transmitter off sends nothing
    wr(serial_pkg::IDX_CTL2, 8'h00);
    n = serial_station_i.got.size();
    wr(serial_pkg::IDX_DATA, 8'h11);
    repeat (1500) @(posedge hclk);
    chk(serial_station_i.got.size(), n);
    results();
  end
endmodule : async_serial_control_tb_top

bind async_serial_control async_serial_control_asserts #(.ADDR_W(ADDR_W))
  async_serial_control_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .rxd(rxd), .txd(txd), .irq(irq));

// ==== dv/serial_station.sv ====
// Remote serial station: frame sender and frame catcher
`timescale 1ns/1ns
module serial_station (
  input wire logic txd,
  input wire logic nine,
  output logic rxd
);
  int bit_ns = 640;
  int bad_stop = 0;
  logic [8:0] got[$];
  logic [8:0] w;

  initial rxd = 1'b1;

  // Start low, data LSB first, ninth if asked, stop
  task automatic send(input logic [8:0] d, input logic n9, input logic stp);
    rxd <= 1'b0;
    #(bit_ns);
    for (int i = 0; i < (n9 ? 9 : 8); i++) begin
      rxd <= d[i];
      #(bit_ns);
    end
    rxd <= stp;
    #(bit_ns);
    rxd <= 1'b1;
    #(bit_ns);
  endtask : send

  // Mid-bit sampling of each frame on the line
  always begin
    @(negedge txd);
    #(bit_ns / 2);
    w = 9'h000;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      #(bit_ns);
      w[i] = txd;
    end
    #(bit_ns);
    if (txd !== 1'b1) bad_stop++;
    got.push_back(w);
  end
endmodule : serial_station

// ==== logic/async_serial_control.sv ====
// Asynchronous serial port: registers, rate generator, transmitter, receiver
`timescale 1ns/1ns

// Contract
// - Frame is start bit, eight or nine data bits, stop bit.
// - Ninth received bit goes to its own field; ninth sent bit from one.
// - Wake bit chooses idle line or address mark to end sleep.
// - Unused control-one bits read zero and ignore writes.
// - Holding-empty flag requests interrupt when its enable is set.
// - Transmit-done flag requests interrupt when its enable is set.
// - Receive-full or overrun flag requests interrupt when enabled.
// - Idle-line flag requests interrupt when its enable is set.
// - Transmitter runs only while its enable bit is one.
// - Receiver runs only while its enable bit is one.
// - Sleep bit makes receiver wait for wakeup, blocking its interrupts.
// - Break frames are sent continuously while the break bit is one.
// - Holding buffer sits between registers and each shift register.
// - Data address reads receive buffer, writes transmit buffer.
// - Ninth-bit fields keep their values after each character.
// - Bit rate is clock over 16, prescaler 1,3,4,13 and power of two.
module async_serial_control #(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  output logic txd,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must be at least 10");
  end

  serial_pkg::state_t r;
  serial_pkg::state_t n;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic pre_tick;
    logic rt_tick;
    logic [6:0] div_mask;
    logic [3:0] nbits;
    logic [7:0] idle_full;
    logic [7:0] w;
    logic [7:0] rd;
    logic wrote;
    logic vote;
    logic unan;
    logic accept;
    logic [3:0] ev;
    pre_tick = 1'b0;
    rt_tick = 1'b0;
    div_mask = '0;
    nbits = '0;
    idle_full = '0;
    w = hwdata[7:0];
    rd = '0;
    wrote = 1'b0;
    vote = 1'b0;
    unan = 1'b0;
    accept = 1'b0;
    ev = '0;
    n = r;

    // Two-stage rate divider giving the oversample tick
    pre_tick = (r.pre_cnt == serial_pkg::pre_last(r.rate_prescale_sel));
    n.pre_cnt = pre_tick ? '0 : r.pre_cnt + 4'h1;
    div_mask = 7'((8'h01 << r.rate_divider_sel) - 8'h01);
    rt_tick = pre_tick && ((r.div_cnt | ~div_mask) == 7'h7f);
    if (pre_tick) begin
      n.div_cnt = r.div_cnt + 7'h01;
    end

    // Frame length in bits and idle-line length in ticks
    nbits = r.nine_bit_mode ? serial_pkg::BITS_NINE
                            : serial_pkg::BITS_EIGHT;
    idle_full = {nbits, 4'h0};

    // Data phase of a write
    if (r.req.valid && r.req.write) begin
      unique case (r.req.idx)
        serial_pkg::IDX_CTL1: begin
          n.tx_ninth_bit = w[serial_pkg::CTL1_TX9];
          n.nine_bit_mode = w[serial_pkg::CTL1_NINE];
          n.wake_by_mark = w[serial_pkg::CTL1_WAKE];
        end
        serial_pkg::IDX_CTL2: n.ctl2 = serial_pkg::ctl2_t'(w);
        serial_pkg::IDX_RATE: begin
          n.rate_prescale_sel = w[serial_pkg::RATE_PRE_LSB +: 2];
          n.rate_divider_sel = w[serial_pkg::RATE_DIV_LSB +: 3];
        end
        serial_pkg::IDX_DATA: begin
          n.tx_hold = w;
          n.hold_full = 1'b1;
          wrote = 1'b1;
          if (r.stat_armed) begin
            n.stat.tx_holding_empty_flag = 1'b0;
            n.stat.tx_done_flag = 1'b0;
          end
          n.stat_armed = 1'b0;
        end
        serial_pkg::IDX_IRQ_STATUS: n.irq_status = r.irq_status & ~w[3:0];
        serial_pkg::IDX_IRQ_MASK: n.irq_mask = w[3:0];
        default: ;
      endcase
    end

    // Address phase: latch request, capture read data
    n.req.valid = hsel && hready && (htrans == serial_pkg::HTRANS_NONSEQ);
    n.req.write = hwrite;
    n.req.idx = haddr[9:2];
    if (n.req.valid && !hwrite) begin
      unique case (n.req.idx)
        serial_pkg::IDX_CTL1: begin
          rd[serial_pkg::CTL1_RX9] = n.rx_ninth_bit;
          rd[serial_pkg::CTL1_TX9] = n.tx_ninth_bit;
          rd[serial_pkg::CTL1_NINE] = n.nine_bit_mode;
          rd[serial_pkg::CTL1_WAKE] = n.wake_by_mark;
        end
        serial_pkg::IDX_CTL2: rd = n.ctl2;
        serial_pkg::IDX_STATUS: begin
          rd = n.stat;
          n.stat_armed = 1'b1;
        end
        serial_pkg::IDX_DATA: begin
          rd = n.rx_buf;
          if (r.stat_armed) begin
            n.stat.rx_full_flag = 1'b0;
            n.stat.idle_line_flag = 1'b0;
            n.stat.overrun_flag = 1'b0;
            n.stat.noise_flag = 1'b0;
            n.stat.framing_error_flag = 1'b0;
          end
          n.stat_armed = 1'b0;
        end
        serial_pkg::IDX_RATE: begin
          rd[serial_pkg::RATE_PRE_LSB +: 2] = n.rate_prescale_sel;
          rd[serial_pkg::RATE_DIV_LSB +: 3] = n.rate_divider_sel;
        end
        serial_pkg::IDX_IRQ_STATUS: rd[3:0] = n.irq_status;
        serial_pkg::IDX_IRQ_MASK: rd[3:0] = n.irq_mask;
        default: rd = '0;
      endcase
      n.rdata = {24'h0, rd};
    end

    // Transmitter
    if (!r.ctl2.transmitter_on) begin
      n.tx_state = serial_pkg::TX_IDLE;
      n.tx_break = 1'b0;
    end else begin
      unique case (r.tx_state)
        serial_pkg::TX_IDLE: begin
          n.tx_sub = '0;
          n.tx_bit = '0;
          if (r.ctl2.send_break_ctrl) begin
            n.tx_state = serial_pkg::TX_SHIFT;
            n.tx_break = 1'b1;
            n.tx_shift = '0;
          end else if (r.hold_full) begin
            // Holding buffer moves into the shifter
            n.tx_state = serial_pkg::TX_SHIFT;
            n.tx_break = 1'b0;
            n.tx_shift = {1'b1, r.nine_bit_mode ? r.tx_ninth_bit : 1'b1,
                          r.tx_hold, 1'b0};
            n.hold_full = wrote;
            n.stat.tx_holding_empty_flag = 1'b1;
          end
        end
        serial_pkg::TX_SHIFT: begin
          if (rt_tick) begin
            n.tx_sub = r.tx_sub + 4'h1;
            if (r.tx_sub == serial_pkg::SUB_LAST) begin
              n.tx_shift = {~r.tx_break, r.tx_shift[10:1]};
              n.tx_bit = r.tx_bit + 4'h1;
              if (r.tx_bit == nbits - 4'h1) begin
                if (r.ctl2.send_break_ctrl) begin
                  // Next break frame follows with no gap
                  n.tx_break = 1'b1;
                  n.tx_shift = '0;
                  n.tx_bit = '0;
                end else begin
                  n.tx_state = serial_pkg::TX_IDLE;
                  n.tx_break = 1'b0;
                  if (!r.hold_full) begin
                    n.stat.tx_done_flag = 1'b1;
                  end
                end
              end
            end
          end
        end
      endcase
    end
    n.txd = (n.ctl2.transmitter_on && n.tx_state == serial_pkg::TX_SHIFT)
            ? n.tx_shift[0] : 1'b1;

    // Receiver
    if (!r.ctl2.receiver_on) begin
      n.rx_state = serial_pkg::RX_IDLE;
      n.idle_cnt = '0;
    end else if (rt_tick) begin
      unique case (r.rx_state)
        serial_pkg::RX_IDLE: begin
          if (!rxd) begin
            n.rx_state = serial_pkg::RX_FRAME;
            n.rx_sub = '0;
            n.rx_bit = '0;
            n.rx_noise = 1'b0;
            n.idle_cnt = '0;
          end else if (r.idle_cnt != idle_full) begin
            n.idle_cnt = r.idle_cnt + 8'h01;
            if (n.idle_cnt == idle_full) begin
              // A full frame time of idle line
              if (r.idle_armed && !r.ctl2.rx_sleep_ctrl) begin
                n.stat.idle_line_flag = 1'b1;
              end
              if (r.ctl2.rx_sleep_ctrl && !r.wake_by_mark) begin
                n.ctl2.rx_sleep_ctrl = 1'b0;
              end
              n.idle_armed = 1'b0;
            end
          end
        end
        serial_pkg::RX_FRAME: begin
          n.rx_sub = r.rx_sub + 4'h1;
          if (r.rx_sub == serial_pkg::SUB_A) begin
            n.rx_smp[0] = rxd;
          end
          if (r.rx_sub == serial_pkg::SUB_B) begin
            n.rx_smp[1] = rxd;
          end
          if (r.rx_sub == serial_pkg::SUB_LAST) begin
            n.rx_bit = r.rx_bit + 4'h1;
          end
          if (r.rx_sub == serial_pkg::SUB_C) begin
            // Majority of three samples per bit
            vote = (r.rx_smp[0] & r.rx_smp[1]) | (r.rx_smp[0] & rxd) |
                   (r.rx_smp[1] & rxd);
            unan = (r.rx_smp[0] == r.rx_smp[1]) && (r.rx_smp[1] == rxd);
            n.rx_noise = r.rx_noise | ~unan;
            if (r.rx_bit == 4'h0) begin
              if (vote) begin
                n.rx_state = serial_pkg::RX_IDLE;
              end
            end else if (r.rx_bit == nbits - 4'h1) begin
              n.rx_state = serial_pkg::RX_IDLE;
              n.idle_armed = 1'b1;
              n.idle_cnt = '0;
              accept = 1'b1;
              if (r.ctl2.rx_sleep_ctrl) begin
                accept = r.wake_by_mark && r.rx_shift[8];
                if (accept) begin
                  n.ctl2.rx_sleep_ctrl = 1'b0;
                end
              end
              if (accept && n.stat.rx_full_flag) begin
                n.stat.overrun_flag = 1'b1;
              end else if (accept) begin
                n.rx_buf = r.nine_bit_mode ? r.rx_shift[7:0]
                                           : r.rx_shift[8:1];
                if (r.nine_bit_mode) begin
                  n.rx_ninth_bit = r.rx_shift[8];
                end
                n.stat.rx_full_flag = 1'b1;
                n.stat.noise_flag = n.rx_noise;
                n.stat.framing_error_flag = ~vote;
              end
            end else begin
              n.rx_shift = {vote, r.rx_shift[8:1]};
            end
          end
        end
      endcase
    end

    // Sticky interrupt events, set wins over write-one-to-clear
    ev[0] = n.stat.tx_holding_empty_flag && n.ctl2.tx_empty_irq_en;
    ev[1] = n.stat.tx_done_flag && n.ctl2.tx_done_irq_en;
    ev[2] = (n.stat.rx_full_flag || n.stat.overrun_flag) &&
            n.ctl2.rx_irq_en && !n.ctl2.rx_sleep_ctrl;
    ev[3] = n.stat.idle_line_flag && n.ctl2.idle_line_irq_en &&
            !n.ctl2.rx_sleep_ctrl;
    n.irq_status = n.irq_status | ev;
    n.irq = |(n.irq_status & n.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.ready <= 1'b1;
      r.txd <= 1'b1;
      r.ctl2 <= serial_pkg::CTL2_RESET;
      r.stat.tx_holding_empty_flag <= 1'b1;
      r.stat.tx_done_flag <= 1'b1;
      r.irq_mask <= serial_pkg::IRQ_MASK_RESET;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign hrdata = r.rdata;
  assign hreadyout = r.ready;
  assign hresp = r.resp;
  assign txd = r.txd;
  assign irq = r.irq;

endmodule : async_serial_control

// ==== logic/serial_pkg.sv ====
// Package: register map, field layout, types and constants of the serial port
package serial_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RATE = 8'h2b;
  localparam logic [7:0] IDX_CTL1 = 8'h2c;
  localparam logic [7:0] IDX_CTL2 = 8'h2d;
  localparam logic [7:0] IDX_STATUS = 8'h2e;
  localparam logic [7:0] IDX_DATA = 8'h2f;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL1_RX9 = 7;
  localparam int unsigned CTL1_TX9 = 6;
  localparam int unsigned CTL1_NINE = 4;
  localparam int unsigned CTL1_WAKE = 3;
  localparam int unsigned RATE_PRE_LSB = 4;
  localparam int unsigned RATE_DIV_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL2_RESET = 8'h00;
  localparam logic [3:0] IRQ_MASK_RESET = 4'hf;
  localparam logic [3:0] SUB_A = 4'h7;
  localparam logic [3:0] SUB_B = 4'h8;
  localparam logic [3:0] SUB_C = 4'h9;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] BITS_EIGHT = 4'ha;
  localparam logic [3:0] BITS_NINE = 4'hb;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Prescaler divide minus one: 1, 3, 4, 13
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: pre_last = 4'h0;
      2'h1: pre_last = 4'h2;
      2'h2: pre_last = 4'h3;
      2'h3: pre_last = 4'hc;
    endcase
  endfunction : pre_last

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_irq_en;
    logic idle_line_irq_en;
    logic transmitter_on;
    logic receiver_on;
    logic rx_sleep_ctrl;
    logic send_break_ctrl;
  } ctl2_t;

  typedef struct packed {
    logic tx_holding_empty_flag;
    logic tx_done_flag;
    logic rx_full_flag;
    logic idle_line_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic spare;
  } status_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } bus_req_t;

  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_t;
  typedef enum logic {RX_IDLE = 1'b0, RX_FRAME = 1'b1} rx_state_t;

  typedef struct packed {
    bus_req_t req;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic nine_bit_mode;
    logic wake_by_mark;
    ctl2_t ctl2;
    status_t stat;
    logic [1:0] rate_prescale_sel;
    logic [2:0] rate_divider_sel;
    logic stat_armed;
    logic [7:0] tx_hold;
    logic hold_full;
    tx_state_t tx_state;
    logic tx_break;
    logic [10:0] tx_shift;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic txd;
    rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic [1:0] rx_smp;
    logic rx_noise;
    logic [7:0] rx_buf;
    logic [7:0] idle_cnt;
    logic idle_armed;
    logic [3:0] pre_cnt;
    logic [6:0] div_cnt;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq;
  } state_t;

endpackage : serial_pkg
